// ===== bench/dead_band_assertions.sv
/* Port checker for the dead-band generator, bound to its top module.
 Assumes control writes use all byte lanes. */
`timescale 1ns/10ps
`default_nettype none
module dead_band_assertions
    import dead_band_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic WE_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic ACK_O,
    input wire logic BRIDGE_OUTPUT_A,
    input wire logic BRIDGE_OUTPUT_B,
    input wire logic BRIDGE_OUTPUT_C,
    input wire logic BRIDGE_OUTPUT_D
);
    // ----------------
    // Snooped settings
    // ----------------
    logic [31:0] ctl_r;
    logic [DB_W-1:0] rise_r, fall_r, alo_r, blo_r;
    logic wr, hb_on, fb_on;
    assign wr = CYC_I && STB_I && WE_I && ACK_O;
    assign hb_on = ctl_r[0] && ctl_r[3:1] == MODE_HALF && ctl_r[11:8] == 4'hF;
    assign fb_on = ctl_r[0] && ctl_r[3:2] == 2'h1 && ctl_r[11:8] == 4'hF;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ctl_r <= 32'h00000F00;
            rise_r <= DB_RST;
            fall_r <= DB_RST;
        end else if (wr && ADR_I == OFS_CONTROL) begin
            ctl_r <= DAT_I;
        end else if (wr && ADR_I == OFS_RISE) begin
            rise_r <= DAT_I[DB_W-1:0];
        end else if (wr && ADR_I == OFS_FALL) begin
            fall_r <= DAT_I[DB_W-1:0];
        end
        alo_r <= RST ? '1 : BRIDGE_OUTPUT_A ? '0 : alo_r + 6'(~&alo_r);
        blo_r <= RST ? '1 : BRIDGE_OUTPUT_B ? '0 : blo_r + 6'(~&blo_r);
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    property p_ack_one; ACK_O |=> !ACK_O; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");
    property p_ack_req; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack missing");
    property p_ack_idle; !(CYC_I && STB_I) |=> !ACK_O; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
    property p_idle_lvl; (!ctl_r[0] && $stable(ctl_r)) [*4] |-> {BRIDGE_OUTPUT_D,
        BRIDGE_OUTPUT_C, BRIDGE_OUTPUT_B, BRIDGE_OUTPUT_A} == ~ctl_r[11:8]; endproperty
    a_idle_lvl: assert property (p_idle_lvl) else $error("idle level");
    property p_half_gap; hb_on |-> !(BRIDGE_OUTPUT_A && BRIDGE_OUTPUT_B); endproperty
    a_half_gap: assert property (p_half_gap) else $error("half overlap");
    property p_full_gap; fb_on |-> !(BRIDGE_OUTPUT_A && BRIDGE_OUTPUT_B)
        && !(BRIDGE_OUTPUT_C && BRIDGE_OUTPUT_D); endproperty
    a_full_gap: assert property (p_full_gap) else $error("full overlap");
    property p_rise_dly; hb_on && $rose(BRIDGE_OUTPUT_A) |-> blo_r >= rise_r; endproperty
    a_rise_dly: assert property (p_rise_dly) else $error("rise early");
    property p_fall_dly; hb_on && $rose(BRIDGE_OUTPUT_B) |-> alo_r >= fall_r; endproperty
    a_fall_dly: assert property (p_fall_dly) else $error("fall early");
endmodule
bind bridge_dead_band_generator dead_band_assertions chk_u (.REF_CLK, .RST, .ADR_I,
    .DAT_I, .WE_I, .CYC_I, .STB_I, .ACK_O, .BRIDGE_OUTPUT_A, .BRIDGE_OUTPUT_B,
    .BRIDGE_OUTPUT_C, .BRIDGE_OUTPUT_D);
`default_nettype wire

// ===== bench/switch_driver_model.sv
/* Bridge switch drivers: counts cycles where both switches of a leg conduct.
 Assumes active-high gate drive; legs are A/B and C/D. */
`timescale 1ns/10ps
`default_nettype none
module switch_driver_model (
    input wire logic clk,
    input wire logic [3:0] gate,
    output logic [7:0] shoot_cnt
);
    initial shoot_cnt = 8'h00;
    always @(posedge clk) begin
        if ((gate[0] && gate[1]) || (gate[2] && gate[3])) begin
            shoot_cnt <= shoot_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb_bridge_dead_band_generator.sv
/* Self-checking bench for the bridge dead-band generator.
 Assumes one dead-band tick per clock and one latency for undelayed edges. */
`timescale 1ns/10ps
`default_nettype none
module tb_bridge_dead_band_generator
    import dead_band_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic mod_in = 1'b0, osc = 1'b0, slp = 1'b0, ack;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h00000000, dat_o, rd;
    logic [7:0] shoot;
    logic [3:0] ra [4] = '{OFS_CONTROL, OFS_RISE, OFS_FALL, 4'h6};
    wire logic [3:0] outs;
    int error_cnt = 0, total_checks = 0, seed = 96563, r, f, lh, p;
    int tc [4];
    bridge_dead_band_generator dut_u (.REF_CLK(clk), .RST(rst), .ADR_I(adr), .DAT_I(dat),
        .SEL_I(4'hF), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .MOD_IN(mod_in),
        .FAST_OSC_TICK(osc), .SLEEP(slp), .DAT_O(dat_o), .ACK_O(ack),
        .BRIDGE_OUTPUT_A(outs[0]), .BRIDGE_OUTPUT_B(outs[1]), .BRIDGE_OUTPUT_C(outs[2]),
        .BRIDGE_OUTPUT_D(outs[3]));
    switch_driver_model drv_u (.clk(clk), .gate(outs), .shoot_cnt(shoot));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) osc <= ~osc;
    initial begin
        #750000;
        error_cnt++;
        conclude();
    end
    // ---------------
    // Tasks
    // ---------------
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic cs);
        return {20'h00000, POL_RST, 3'h0, cs, m, 1'b1};
    endfunction
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] wd);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, wd};
        repeat (20) begin
            @(negedge clk);
            if (ack === 1'b1) break;
        end
        rd = dat_o;
        chk(ack === 1'b1, "no ack");
        @(posedge clk);
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic drive(input logic lvl);
        logic [3:0] prev;
        prev = outs;
        tc = '{-1, -1, -1, -1};
        mod_in <= lvl;
        for (int i = 0; i < 90; i++) begin
            @(posedge clk);
            for (int k = 0; k < 4; k++) begin
                if (tc[k] < 0 && outs[k] !== prev[k]) tc[k] = i;
            end
        end
    endtask
    task automatic pulse();
        drive(1'b0);
        drive(1'b1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wb(1'b0, ra[k], 32'h00000000);
            chk(rd === (k == 0 ? 32'h00000F00 : 32'h00000000), "reset value");
        end
        for (int it = 0; it < 6; it++) begin
            r = it == 0 ? 0 : it == 1 ? 63 : $random(seed) & 63;
            f = it == 0 ? 63 : it == 1 ? 0 : $random(seed) & 63;
            wb(1'b1, OFS_CONTROL, 32'h00000F00);
            wb(1'b1, OFS_RISE, {$random(seed)} & 32'hFFFFFFC0 | r);
            wb(1'b1, OFS_FALL, {$random(seed)} & 32'hFFFFFFC0 | f);
            wb(1'b0, OFS_RISE, 32'h00000000);
            chk(rd === 32'(r), "rise setting");
            wb(1'b1, OFS_CONTROL, ctl(MODE_HALF, 1'b0));
            pulse();
            lh = tc[1];
            chk(tc[1] >= 0 && tc[0] - tc[1] === r && tc[2] === tc[0], "rise gap");
            drive(1'b0);
            chk(tc[0] >= 0 && tc[1] - tc[0] === f && tc[3] === tc[1], "fall gap");
        end
        wb(1'b1, OFS_RISE, 32'h00000014);
        slp <= 1'b1;
        drive(1'b1);
        chk(tc[1] >= 0 && tc[0] === -1, "ran in sleep");
        wb(1'b1, OFS_CONTROL, ctl(MODE_HALF, 1'b1));
        pulse();
        chk(tc[0] - tc[1] >= 20 && tc[0] - tc[1] <= 22, "fast clock gap");
        slp <= 1'b0;
        wb(1'b1, OFS_CONTROL, 32'h00000F00);
        wb(1'b1, OFS_CONTROL, ctl(MODE_FWD, 1'b0));
        pulse();
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, OFS_CONTROL, ctl(k == 0 ? MODE_REV : MODE_FWD, 1'b0));
            pulse();
            chk(tc[0] === lh && tc[2] === lh, "steer switch");
            chk(tc[k == 0 ? 1 : 3] === lh + (k == 0 ? 20 : f), "turn delay");
            pulse();
            chk(tc[k == 0 ? 1 : 3] === lh, "plain edge");
        end
        chk(shoot === 8'h00, "overlap");
        for (int k = 0; k < 4; k++) begin
            p = $random(seed) & 15;
            wb(1'b1, OFS_CONTROL, 32'(p) << CTL_POL_LSB);
            repeat (4) @(posedge clk);
            chk(outs === ~4'(p), "idle level");
        end
        conclude();
    end
endmodule
`default_nettype wire

// ===== rtl/bridge_dead_band_generator.sv
/*
 Dead-band generator of the complementary waveform unit with Wishbone registers.
 Assumes the modulating input and the fast oscillator tick arrive asynchronously;
 SLEEP is a level from the power controller.
*/
`timescale 1ns/10ps
`default_nettype none
module bridge_dead_band_generator
    import dead_band_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic [3:0] SEL_I,
    input wire logic WE_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic MOD_IN,
    input wire logic FAST_OSC_TICK,
    input wire logic SLEEP,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic BRIDGE_OUTPUT_A,
    output logic BRIDGE_OUTPUT_B,
    output logic BRIDGE_OUTPUT_C,
    output logic BRIDGE_OUTPUT_D
);

    typedef struct packed {
        logic en;
        logic [2:0] mode;
        logic cs;
        logic [3:0] pol;
        logic ovr_en;
        logic [3:0] ovr;
        logic [DB_W-1:0] rise;
        logic [DB_W-1:0] fall;
        logic [2:0] in_sync;
        logic in_q;
        logic [2:0] osc_sync;
        logic dir;
        logic dir_pend;
        logic ac_dir;
        logic [3:0] act;
        logic [3:0] pin;
        logic [31:0] dat;
        logic ack;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;

    logic in_rise;
    logic in_fall;
    logic tick;
    logic rise_start;
    logic fall_start;
    logic rise_done;
    logic fall_done;
    logic bus_req;

    function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                              input logic en_v);
        lane_merge = en_v ? new_v : old_v;
    endfunction

    function automatic logic is_full(input logic [2:0] m);
        is_full = (m == MODE_FWD) || (m == MODE_REV);
    endfunction

    // ------------------------------------------------------------
    // Edge detect and dead-band clock
    // ------------------------------------------------------------
    assign in_rise = s_r.in_sync[2] && !s_r.in_q;
    assign in_fall = !s_r.in_sync[2] && s_r.in_q;
    assign tick = s_r.cs ? (s_r.osc_sync[2] != s_r.osc_sync[1]) : !SLEEP;
    assign bus_req = CYC_I && STB_I && !s_r.ack;

    // Half bridge: rising counter on input rise, falling counter on input fall
    // Full bridge: counters start only on the edge that applies a direction change
    always_comb begin
        rise_start = 1'b0;
        fall_start = 1'b0;
        if (s_r.mode == MODE_HALF) begin
            rise_start = in_rise;
            fall_start = in_fall;
        end else if (is_full(s_r.mode) && s_r.dir_pend && in_rise) begin
            rise_start = s_r.dir;
            fall_start = !s_r.dir;
        end
    end

    dead_time_counter rise_cnt (
        .clk(REF_CLK),
        .rst(RST),
        .start(rise_start),
        .tick(tick),
        .setting(s_r.rise),
        .expired(rise_done)
    );

    dead_time_counter fall_cnt (
        .clk(REF_CLK),
        .rst(RST),
        .start(fall_start),
        .tick(tick),
        .setting(s_r.fall),
        .expired(fall_done)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] ctl;
        logic [31:0] wdat;
        logic [3:0] lvl;
        ctl = 32'h0000_0000;
        wdat = 32'h0000_0000;
        lvl = 4'h0;
        s_nxt = s_r;

        s_nxt.in_sync = {s_r.in_sync[1:0], MOD_IN};
        s_nxt.in_q = s_r.in_sync[2];
        s_nxt.osc_sync = {s_r.osc_sync[1:0], FAST_OSC_TICK};

        // Register bus
        ctl[CTL_EN_BIT] = s_r.en;
        ctl[CTL_MODE_LSB +: 3] = s_r.mode;
        ctl[CTL_CS_BIT] = s_r.cs;
        ctl[CTL_POL_LSB +: 4] = s_r.pol;
        ctl[CTL_OVR_EN_BIT] = s_r.ovr_en;
        ctl[CTL_OVR_LSB +: 4] = s_r.ovr;
        s_nxt.ack = bus_req;
        if (bus_req) begin
            for (int i = 0; i < 4; i++) begin
                wdat[8*i +: 8] = lane_merge(ctl[8*i +: 8], DAT_I[8*i +: 8], SEL_I[i]);
            end
            case (ADR_I)
                OFS_CONTROL: s_nxt.dat = ctl;
                OFS_RISE: s_nxt.dat = {26'h0, s_r.rise};
                OFS_FALL: s_nxt.dat = {26'h0, s_r.fall};
                OFS_STATUS: s_nxt.dat = {24'h0, s_r.dir_pend, s_r.dir, s_r.act, rise_done, fall_done};
                default: s_nxt.dat = 32'h0000_0000;
            endcase
            if (WE_I) begin
                case (ADR_I)
                    OFS_CONTROL: begin
                        s_nxt.en = wdat[CTL_EN_BIT];
                        s_nxt.mode = wdat[CTL_MODE_LSB +: 3];
                        s_nxt.cs = wdat[CTL_CS_BIT];
                        s_nxt.pol = wdat[CTL_POL_LSB +: 4];
                        s_nxt.ovr_en = wdat[CTL_OVR_EN_BIT];
                        s_nxt.ovr = wdat[CTL_OVR_LSB +: 4];
                    end
                    OFS_RISE: if (SEL_I[0]) s_nxt.rise = DAT_I[DB_W-1:0];
                    OFS_FALL: if (SEL_I[0]) s_nxt.fall = DAT_I[DB_W-1:0];
                    default: s_nxt.dat = 32'h0000_0000;
                endcase
            end
        end

        // Direction tracking; a write while running only marks a pending change
        if (is_full(s_nxt.mode) && s_nxt.mode[0] != s_r.dir) begin
            s_nxt.dir = s_nxt.mode[0];
            s_nxt.dir_pend = 1'b1;
        end
        if (is_full(s_r.mode) && s_r.dir_pend && in_rise) begin
            s_nxt.dir_pend = 1'b0;
            s_nxt.ac_dir = s_r.dir;
        end

        // Active-level drive, before polarity
        if (!s_r.en) begin
            s_nxt.act = 4'h0;
        end else if (s_r.mode == MODE_HALF) begin
            // A normal, B inverted, each leading edge delayed
            s_nxt.act[0] = s_r.in_q && rise_done;
            s_nxt.act[1] = !s_r.in_q && fall_done;
            s_nxt.act[2] = s_nxt.act[0];
            s_nxt.act[3] = s_nxt.act[1];
        end else if (is_full(s_r.mode)) begin
            // Forward: A on, D modulated; reverse: C on, B modulated
            s_nxt.act[0] = !s_r.ac_dir;
            s_nxt.act[2] = s_r.ac_dir;
            s_nxt.act[3] = !s_r.ac_dir && !s_r.dir_pend && s_r.in_q && fall_done;
            s_nxt.act[1] = s_r.ac_dir && !s_r.dir_pend && s_r.in_q && rise_done;
            if (s_r.in_q && s_r.act[1] && !s_r.ac_dir) begin
                s_nxt.act[3] = 1'b0;
            end
            if (s_r.in_q && s_r.act[3] && s_r.ac_dir) begin
                s_nxt.act[1] = 1'b0;
            end
        end else begin
            s_nxt.act = {4{s_r.in_q}};
        end

        // Polarity, then override levels which polarity does not touch
        lvl = ~(s_nxt.act ^ s_r.pol);
        s_nxt.pin = s_r.ovr_en ? s_r.ovr : lvl;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_r <= '{en: 1'b0, mode: MODE_RST, cs: 1'b0, pol: POL_RST, ovr_en: 1'b0,
                     ovr: 4'h0, rise: DB_RST, fall: DB_RST, in_sync: 3'h0, in_q: 1'b0,
                     osc_sync: 3'h0, dir: 1'b0, dir_pend: 1'b0, ac_dir: 1'b0,
                     act: 4'h0, pin: 4'h0, dat: 32'h0000_0000, ack: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign DAT_O = s_r.dat;
    assign ACK_O = s_r.ack;
    assign BRIDGE_OUTPUT_A = s_r.pin[0];
    assign BRIDGE_OUTPUT_B = s_r.pin[1];
    assign BRIDGE_OUTPUT_C = s_r.pin[2];
    assign BRIDGE_OUTPUT_D = s_r.pin[3];

endmodule
`default_nettype wire

// ===== rtl/dead_band_pkg.sv
/*
 Constants, register map and types for the bridge dead-band generator.
 Assumes a classic Wishbone slave with 32-bit data and byte addressing.
*/
package dead_band_pkg;

    localparam int DB_W = 6;
    localparam int ADDR_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RISE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_FALL = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

    // Control field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_MODE_LSB = 1;
    localparam int CTL_CS_BIT = 4;
    localparam int CTL_POL_LSB = 8;
    localparam int CTL_OVR_EN_BIT = 12;
    localparam int CTL_OVR_LSB = 16;

    // Reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [3:0] POL_RST = 4'hF;
    localparam logic [DB_W-1:0] DB_RST = 6'h00;

    // Operating modes; bit 0 of a full-bridge code is the direction
    localparam logic [2:0] MODE_STEER = 3'h0;
    localparam logic [2:0] MODE_HALF = 3'h4;
    localparam logic [2:0] MODE_FWD = 3'h2;
    localparam logic [2:0] MODE_REV = 3'h3;

    typedef enum logic [1:0] {
        DB_IDLE,
        DB_RUN,
        DB_DONE
    } db_state_t;

endpackage

// ===== rtl/dead_time_counter.sv
/*
 One 6-bit dead-time counter.
 Assumes tick is a one-cycle enable of the dead-band clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dead_time_counter
    import dead_band_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic tick,
    input wire logic [DB_W-1:0] setting,
    output logic expired
);

    typedef struct packed {
        db_state_t st;
        logic [DB_W-1:0] cnt;
    } cnt_state_t;

    cnt_state_t s_r;
    cnt_state_t s_nxt;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (start) begin
            s_nxt.cnt = DB_RST;
            s_nxt.st = (setting == DB_RST) ? DB_DONE : DB_RUN;
        end else begin
            case (s_r.st)
                DB_RUN: begin
                    if (tick) begin
                        s_nxt.cnt = s_r.cnt + 6'h01;
                        if (s_r.cnt + 6'h01 >= setting) begin
                            s_nxt.st = DB_DONE;
                        end
                    end
                end
                DB_IDLE: s_nxt.st = DB_IDLE;
                DB_DONE: s_nxt.st = DB_DONE;
                default: s_nxt.st = DB_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{st: DB_DONE, cnt: DB_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expired = (s_r.st == DB_DONE) && !start;

endmodule
`default_nettype wire
